//--- src/twi_pkg.sv
// Purpose: Shared constants for the two-wire serial memory and its master.
// Assumes: One system clock at 100 MHz; the link runs at 100 kHz.
// Notes: Every count of cycles is derived here from a time and the rate.
package twi_pkg;
   // Storage geometry.
   localparam int MEM_WORDS = 128;
   localparam int ADDR_W = 7;
   localparam int BYTE_W = 8;
   localparam int PAGE_BYTES = 4;
   // Bits per byte on the link; the slot after them carries the acknowledge.
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   // System clock rate.
   localparam int CLK_MHZ = 100;
   // Self-timed programming time, in microseconds, and its cycle count.
   localparam int WRITE_TIME_US = 10000;
   localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
   localparam int WCNT_W = 20;
   // Link clock rate, and one quarter of its period in system cycles.
   localparam int SCL_KHZ = 100;
   localparam int QUARTER_CYCLES = (CLK_MHZ * 1000) / (SCL_KHZ * 4);
   localparam int QCNT_W = 8;
   // Byte count of one master command, one to four.
   localparam int LEN_W = 3;
endpackage

//--- src/twi_if.sv
// Purpose: Two-wire link between the bus master and the memory.
// Assumes: The data wire has a pull-up; both ends only pull it low.
// Notes: Enables are active low; the wire level is resolved here.
`timescale 1ns/1ns
interface twi_if;
   logic scl;
   logic m_sda_out;
   logic m_sda_oe_n;
   logic s_sda_out;
   logic s_sda_oe_n;
   logic sda;

   // Wired-AND of both open-drain drivers with a pull-up.
   assign sda = !((!m_sda_oe_n && !m_sda_out) ||
                  (!s_sda_oe_n && !s_sda_out));

   modport master (output scl, m_sda_out, m_sda_oe_n, input sda);
   modport slave (input scl, sda, output s_sda_out, s_sda_oe_n);
endinterface

//--- src/twi_eeprom_slave.sv
// Purpose: Slave end of a small two-wire serial memory of 128 bytes.
// Assumes: Link lines arrive from outside and are synchronised here.
// Notes: One command byte holds address and direction; RESET is the
// power-on reset of the memory.
`timescale 1ns/1ns
module twi_eeprom_slave
   import twi_pkg::*;
#(
   parameter int unsigned WRITE_CYCLES_P = WRITE_CYCLES
) (
   // Clock and power-on reset.
   input wire logic MCLK,
   input wire logic RESET,
   // Two-wire link.
   twi_if.slave LINK,
   // Write protect input and programming status.
   input wire logic WRITE_PROTECT_IN,
   output logic BUSY
);

   typedef enum logic [2:0] {
      S_IDLE, S_CMD, S_ACK, S_WDATA, S_RDATA, S_RACK, S_PROG
   } st_t;

   typedef struct packed {
      logic [1:0] scl_sy;
      logic [1:0] sda_sy;
      logic [1:0] wp_sy;
      logic scl_p;
      logic sda_p;
      st_t st;
      logic [3:0] bits;
      logic [BYTE_W-1:0] sh;
      logic [ADDR_W-1:0] addr;
      logic rw;
      logic ack_on;
      logic m_ack;
      logic drv_low;
      logic [PAGE_BYTES-1:0] mask;
      logic [PAGE_BYTES-1:0][BYTE_W-1:0] pbuf;
      logic [WCNT_W-1:0] wcnt;
      logic [MEM_WORDS-1:0][BYTE_W-1:0] mem;
   } state_t;

   state_t q;
   state_t d;
   logic scl;
   logic sda;
   logic rise;
   logic fall;
   logic start;
   logic stop;
   logic wp;
   logic [BYTE_W-1:0] rd_byte;

   // Edge and condition detection on the second synchroniser stage only.
   assign scl = q.scl_sy[1];
   assign sda = q.sda_sy[1];
   assign rise = scl && !q.scl_p;
   assign fall = !scl && q.scl_p;
   assign start = scl && q.scl_p && q.sda_p && !sda;
   assign stop = scl && q.scl_p && !q.sda_p && sda;
   // Only a solid high protects; an unknown or floating level reads as low,
   // because an if on an unknown condition takes the else branch.
   always_comb begin
      if (q.wp_sy[1]) begin
         wp = 1'b1;
      end else begin
         wp = 1'b0;
      end
   end
   assign rd_byte = q.mem[q.addr];

   // Next-state logic of the whole slave.
   always_comb begin
      logic load;
      load = 1'b0;
      d = q;
      d.scl_sy = {q.scl_sy[0], LINK.scl};
      d.sda_sy = {q.sda_sy[0], LINK.sda};
      d.wp_sy = {q.wp_sy[0], WRITE_PROTECT_IN};
      d.scl_p = scl;
      d.sda_p = sda;
      if (q.st == S_PROG) begin
         // The bus is not watched while the array is programmed.
         d.wcnt = q.wcnt + 1'b1;
         if (q.wcnt == WCNT_W'(WRITE_CYCLES_P - 1)) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
               if (q.mask[i]) begin
                  d.mem[{q.addr[ADDR_W-1:2], 2'(i)}] = q.pbuf[i];
               end
            end
            d.mask = '0;
            d.st = S_IDLE;
         end
      end else if (start) begin
         // A start outside programming aborts the transfer in progress and opens a command.
         d.st = S_CMD;
         d.bits = '0;
         d.drv_low = 1'b0;
         d.ack_on = 1'b0;
         d.mask = '0;
      end else if (stop) begin
         d.drv_low = 1'b0;
         if ((q.st == S_WDATA || q.st == S_ACK) && !q.rw &&
             q.mask != '0 && !wp) begin
            d.st = S_PROG;
            d.wcnt = '0;
         end else begin
            d.st = S_IDLE;
            d.mask = '0;
         end
      end else begin
         case (q.st)
            S_CMD, S_WDATA: begin
               if (rise) begin
                  d.sh = {q.sh[BYTE_W-2:0], sda};
                  d.bits = q.bits + 1'b1;
                  if (q.bits == BITS_PER_BYTE - 1'b1) begin
                     d.st = S_ACK;
                     d.bits = '0;
                     if (q.st == S_CMD) begin
                        // Seven address bits first, direction last.
                        d.addr = q.sh[ADDR_W-1:0];
                        d.rw = sda;
                     end else begin
                        d.pbuf[q.addr[1:0]] = {q.sh[BYTE_W-2:0], sda};
                        d.mask[q.addr[1:0]] = 1'b1;
                        d.addr = {q.addr[ADDR_W-1:2],
                                  q.addr[1:0] + 2'h1};
                     end
                  end
               end
            end
            S_ACK: begin
               if (fall) begin
                  if (!q.ack_on) begin
                     d.ack_on = 1'b1;
                     d.drv_low = 1'b1;
                  end else begin
                     d.ack_on = 1'b0;
                     if (q.rw) begin
                        load = 1'b1;
                     end else begin
                        d.drv_low = 1'b0;
                        d.st = S_WDATA;
                     end
                  end
               end
            end
            S_RDATA: begin
               if (fall) begin
                  if (q.bits == BITS_PER_BYTE) begin
                     d.drv_low = 1'b0;
                     d.st = S_RACK;
                  end else begin
                     d.drv_low = !q.sh[BYTE_W-1];
                     d.sh = {q.sh[BYTE_W-2:0], 1'b0};
                     d.bits = q.bits + 1'b1;
                  end
               end
            end
            S_RACK: begin
               if (rise) begin
                  d.m_ack = !sda;
               end else if (fall) begin
                  if (q.m_ack) begin
                     load = 1'b1;
                  end else begin
                     d.st = S_IDLE;
                  end
               end
            end
            default: begin
            end
         endcase
      end
      // Put out the first bit of the next read byte and step the address.
      if (load) begin
         d.sh = {rd_byte[BYTE_W-2:0], 1'b0};
         d.drv_low = !rd_byte[BYTE_W-1];
         d.bits = 4'h1;
         d.addr = q.addr + 1'b1;
         d.st = S_RDATA;
      end
   end

   // State register; reset holds the port idle and the line released.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Open-drain data drive and status.
   assign LINK.s_sda_out = 1'b0;
   assign LINK.s_sda_oe_n = !q.drv_low;
   assign BUSY = (q.st == S_PROG);
endmodule // twi_eeprom_slave

//--- src/twi_master_ctl.sv
// Purpose: Bus master end that runs one command on the two-wire memory.
// Assumes: A command carries one to four data bytes.
// Notes: Each link bit takes four quarter periods of the link clock.
`timescale 1ns/1ns
module twi_master_ctl
   import twi_pkg::*;
(
   // Clock and reset.
   input wire logic MCLK,
   input wire logic RESET,
   // Two-wire link.
   twi_if.master LINK,
   // Command request.
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire logic CMD_READ,
   input wire logic [ADDR_W-1:0] CMD_ADDR,
   input wire logic [LEN_W-1:0] CMD_LEN,
   input wire logic [PAGE_BYTES*BYTE_W-1:0] CMD_WDATA,
   // Command result.
   output logic DONE,
   output logic NACK,
   output logic [PAGE_BYTES*BYTE_W-1:0] RD_DATA
);

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} hst_t;

   typedef struct packed {
      hst_t st;
      logic [QCNT_W-1:0] qcnt;
      logic [1:0] ph;
      logic [3:0] bit_i;
      logic [LEN_W-1:0] byte_i;
      logic [BYTE_W-1:0] sh;
      logic rd;
      logic [LEN_W-1:0] len;
      logic [PAGE_BYTES-1:0][BYTE_W-1:0] wdata;
      logic [PAGE_BYTES-1:0][BYTE_W-1:0] rdata;
      logic scl_low;
      logic sda_drv;
      logic nack;
      logic done;
      logic [1:0] sda_sy;
   } state_t;

   state_t q;
   state_t d;
   logic tick;
   logic sending;

   // Quarter-period enable and whether the master owns the data bits.
   assign tick = (q.qcnt == QCNT_W'(QUARTER_CYCLES - 1));
   assign sending = (q.byte_i == '0) || !q.rd;

   // Next-state logic of the master sequencer.
   always_comb begin
      d = q;
      d.done = 1'b0;
      d.sda_sy = {q.sda_sy[0], LINK.sda};
      d.qcnt = tick ? '0 : q.qcnt + 1'b1;
      case (q.st)
         H_IDLE: begin
            if (CMD_VALID) begin
               d.st = H_START;
               d.ph = '0;
               d.sh = {CMD_ADDR, CMD_READ};
               d.rd = CMD_READ;
               d.len = CMD_LEN;
               d.wdata = CMD_WDATA;
               d.byte_i = '0;
               d.bit_i = '0;
               d.nack = 1'b0;
            end
         end
         H_START: begin
            if (tick) begin
               if (q.ph == 2'h0) begin
                  d.sda_drv = 1'b1;
                  d.ph = 2'h1;
               end else begin
                  d.scl_low = 1'b1;
                  d.ph = 2'h0;
                  d.st = H_BIT;
               end
            end
         end
         H_BIT: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: begin
                     // Data changes only in the low half of the clock.
                     if (q.bit_i < BITS_PER_BYTE) begin
                        d.sda_drv = sending && !q.sh[BYTE_W-1];
                     end else if (sending) begin
                        d.sda_drv = 1'b0;
                     end else begin
                        d.sda_drv = (q.byte_i != q.len);
                     end
                  end
                  2'h1: begin
                     d.scl_low = 1'b0;
                  end
                  2'h2: begin
                     if (q.bit_i < BITS_PER_BYTE) begin
                        d.sh = {q.sh[BYTE_W-2:0], q.sda_sy[1]};
                     end else if (sending && q.sda_sy[1]) begin
                        d.nack = 1'b1;
                     end
                  end
                  default: begin
                     d.scl_low = 1'b1;
                     if (q.bit_i < BITS_PER_BYTE) begin
                        d.bit_i = q.bit_i + 1'b1;
                     end else begin
                        d.bit_i = '0;
                        if (!sending) begin
                           d.rdata[2'(q.byte_i - 1'b1)] = q.sh;
                        end
                        if (q.nack || q.byte_i == q.len) begin
                           d.st = H_STOP;
                        end else begin
                           d.byte_i = q.byte_i + 1'b1;
                           d.sh = q.wdata[2'(q.byte_i)];
                        end
                     end
                  end
               endcase
            end
         end
         H_STOP: begin
            if (tick) begin
               d.ph = q.ph + 2'h1;
               case (q.ph)
                  2'h0: d.sda_drv = 1'b1;
                  2'h1: d.scl_low = 1'b0;
                  2'h2: d.sda_drv = 1'b0;
                  default: begin
                     d.st = H_IDLE;
                     d.done = 1'b1;
                  end
               endcase
            end
         end
         default: d.st = H_IDLE;
      endcase
   end

   // State register; reset leaves both lines released high.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Link drive and user-side results.
   assign LINK.scl = !q.scl_low;
   assign LINK.m_sda_out = 1'b0;
   assign LINK.m_sda_oe_n = !q.sda_drv;
   assign CMD_READY = (q.st == H_IDLE);
   assign DONE = q.done;
   assign NACK = q.nack;
   assign RD_DATA = q.rdata;
endmodule // twi_master_ctl

//--- tb/twi_monitor.sv
// Purpose: Watches the two-wire link between master and memory.
// Assumes: Link lines are sampled by the system clock, no filtering.
// Notes: Tracks frame, slot and byte to judge who may pull the data wire.
`timescale 1ns/1ns
module twi_monitor (
   // Clock and power-on reset.
   input wire logic MCLK,
   input wire logic RESET,
   // Link lines.
   input wire logic scl,
   input wire logic sda,
   input wire logic s_sda_out,
   input wire logic s_sda_oe_n
);
   logic scl_q, sda_q, started_q, rw_q, cack_q;
   logic [3:0] bit_q;
   logic [1:0] byte_q;
   logic start_w, stop_w, rise_w, fall_w;
   // Bus conditions seen between the last sample and this one.
   assign start_w = scl_q && scl && sda_q && !sda;
   assign stop_w = scl_q && scl && !sda_q && sda;
   assign rise_w = !scl_q && scl;
   assign fall_w = scl_q && !scl;
   // Follows frame, bit slot, byte number, direction and command ack.
   always_ff @(posedge MCLK or posedge RESET) begin
      if (RESET) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         started_q <= 1'b0;
         rw_q <= 1'b0;
         cack_q <= 1'b0;
         bit_q <= 4'h0;
         byte_q <= 2'h0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start_w) begin
            started_q <= 1'b1;
            bit_q <= 4'h0;
            byte_q <= 2'h0;
         end else if (stop_w) begin
            started_q <= 1'b0;
         end else if (rise_w && bit_q == 4'h8) begin
            bit_q <= 4'h0;
            if (byte_q != 2'h3) byte_q <= byte_q + 2'h1;
            if (byte_q == 2'h0) cack_q <= !sda;
         end else if (rise_w) begin
            bit_q <= bit_q + 4'h1;
            if (byte_q == 2'h0 && bit_q == 4'h7) rw_q <= sda;
         end
      end
   end
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RESET);
   // Rules on the slave's use of the data wire and on the idle link clock.
   slave_zero_a: assert property (s_sda_out == 1'b0)
      else $error("Slave data output not held low");
   release_idle_a: assert property (
      $fell(RESET) |-> s_sda_oe_n && scl)
      else $error("Link not idle after reset");
   no_start_quiet_a: assert property (
      !s_sda_oe_n |-> started_q)
      else $error("Slave pulled data outside a frame");
   change_low_a: assert property (
      $changed(s_sda_oe_n) |-> !scl)
      else $error("Slave changed data while clock high");
   rx_released_a: assert property (
      rise_w && started_q && bit_q < 4'h8 &&
      (byte_q == 2'h0 || !rw_q) |-> s_sda_oe_n)
      else $error("Slave drove data while receiving");
   rd_slot_free_a: assert property (
      rise_w && started_q && bit_q == 4'h8 &&
      byte_q != 2'h0 && rw_q |-> s_sda_oe_n)
      else $error("Slave held data in the read ack slot");
   ack_window_a: assert property (
      fall_w && started_q && bit_q == 4'h8 &&
      byte_q != 2'h0 && !rw_q && cack_q |-> ##[1:8] !s_sda_oe_n)
      else $error("Slave ack did not start in time");
   ack_held_a: assert property (
      rise_w && started_q && bit_q == 4'h8 &&
      byte_q != 2'h0 && !rw_q && cack_q |-> !s_sda_oe_n)
      else $error("Slave ack missing at ninth clock");
   clock_idle_a: assert property (
      !started_q && !start_w |-> scl)
      else $error("Link clock low outside a frame");
endmodule // twi_monitor

//--- tb/two_wire_eeprom_slave_port_tb_top.sv
// Purpose: Runs master and memory against each other and a spare link.
// Assumes: Short programming time set by parameter.
// Notes: The spare link is clocked by the bench at 80 ns per bit.
`timescale 1ns/1ns
module two_wire_eeprom_slave_port_tb_top
   import twi_pkg::*;
   ;
   localparam int WCYC = 15000;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic wp_in = 1'b0;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic [ADDR_W-1:0] cmd_addr = 7'h00;
   logic [LEN_W-1:0] cmd_len = 3'h1;
   logic [31:0] cmd_wdata = 32'h0;
   logic cmd_ready, done, nack, busy, busy_b;
   logic [31:0] rd_data;
   logic [7:0] mem [128];
   int err_total = 0;
   int n_tests = 0;
   twi_if link ();
   twi_if rogue ();
   // System clock of 10 ns.
   always #5 mclk = ~mclk;
   // Design ends joined by the main link, and a memory on the spare one.
   twi_eeprom_slave #(.WRITE_CYCLES_P(WCYC)) i_twi_eeprom_slave (
      .MCLK(mclk), .RESET(reset), .LINK(link.slave),
      .WRITE_PROTECT_IN(wp_in), .BUSY(busy));
   twi_eeprom_slave #(.WRITE_CYCLES_P(WCYC)) i_twi_eeprom_slave_b (
      .MCLK(mclk), .RESET(reset), .LINK(rogue.slave),
      .WRITE_PROTECT_IN(1'b0), .BUSY(busy_b));
   twi_master_ctl i_twi_master_ctl (
      .MCLK(mclk), .RESET(reset), .LINK(link.master),
      .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD_READ(cmd_read),
      .CMD_ADDR(cmd_addr), .CMD_LEN(cmd_len), .CMD_WDATA(cmd_wdata),
      .DONE(done), .NACK(nack), .RD_DATA(rd_data));
   twi_monitor i_twi_monitor (
      .MCLK(mclk), .RESET(reset), .scl(link.scl), .sda(link.sda),
      .s_sda_out(link.s_sda_out), .s_sda_oe_n(link.s_sda_oe_n));
   // Counts a comparison and reports a mismatch.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic conclude();
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Hands one command to the master and waits for its completion.
   task automatic run(input logic rd, input logic [6:0] a, input int n,
                      input logic [31:0] wd);
      int i;
      cmd_valid = 1'b1;
      cmd_read = rd;
      cmd_addr = a;
      cmd_len = 3'(n);
      cmd_wdata = wd;
      @(negedge mclk);
      cmd_valid = 1'b0;
      for (i = 0; i < 60000 && done !== 1'b1; i++) @(negedge mclk);
      if (i == 60000) begin
         err_total++;
         conclude();
      end
      chk(cmd_ready, 1'b1);
   endtask
   // Reference memory write; the offset wraps inside the four-byte page.
   task automatic mwrite(input logic [6:0] a, input int n,
                         input logic [31:0] wd);
      for (int k = 0; k < n; k++) mem[{a[6:2], 2'(a[1:0] + k)}] = wd[8*k +: 8];
   endtask
   // Reference read; the address runs on over the whole array.
   function automatic logic [31:0] mread(input logic [6:0] a, input int n);
      logic [31:0] r;
      r = 32'h0;
      for (int k = 0; k < n; k++) r[8*k +: 8] = mem[7'(a + k)];
      return r;
   endfunction
   // Clocks one bit onto the spare link and returns the wire level.
   task automatic lbit(input logic b, output logic s);
      rogue.scl = 1'b0;
      repeat (2) @(negedge mclk);
      rogue.m_sda_oe_n = b;
      repeat (2) @(negedge mclk);
      rogue.scl = 1'b1;
      repeat (2) @(negedge mclk);
      s = rogue.sda;
      repeat (2) @(negedge mclk);
   endtask
   // Sends a command byte, optionally after a start; returns the ack slot.
   task automatic lbyte(input logic st, input logic [7:0] v, output logic s);
      if (st) begin
         rogue.m_sda_oe_n = 1'b0;
         repeat (4) @(negedge mclk);
      end
      for (int k = 7; k >= 0; k--) lbit(v[k], s);
      lbit(1'b1, s);
   endtask
   // Main sequence: spare link first, then master commands.
   initial begin
      logic s;
      logic [31:0] wd;
      int i;
      void'($urandom(11869));
      foreach (mem[k]) mem[k] = 8'h00;
      rogue.scl = 1'b1;
      rogue.m_sda_out = 1'b0;
      rogue.m_sda_oe_n = 1'b1;
      repeat (12) @(negedge mclk);
      reset = 1'b0;
      repeat (4) @(negedge mclk);
      lbyte(1'b0, 8'h00, s);
      chk(s, 1'b1);
      lbyte(1'b1, 8'h0a, s);
      chk(s, 1'b0);
      rogue.scl = 1'b0;
      repeat (4) @(negedge mclk);
      rogue.m_sda_oe_n = 1'b0;
      repeat (4) @(negedge mclk);
      rogue.scl = 1'b1;
      repeat (4) @(negedge mclk);
      rogue.m_sda_oe_n = 1'b1;
      repeat (20) @(negedge mclk);
      chk(busy_b, 1'b0);
      wd = $urandom();
      wp_in = 1'bz;
      run(1'b0, 7'h7f, 2, wd);
      chk(nack, 1'b0);
      chk(busy, 1'b1);
      mwrite(7'h7f, 2, wd);
      run(1'b1, 7'h7c, 4, 32'h0);
      chk(nack, 1'b1);
      for (i = 0; i < 20000 && busy !== 1'b0; i++) @(negedge mclk);
      chk(busy, 1'b0);
      if (i == 20000) conclude();
      wp_in = 1'b1;
      run(1'b0, 7'h7d, 1, $urandom());
      chk(nack, 1'b0);
      repeat (8) @(negedge mclk);
      chk(busy, 1'b0);
      wp_in = 1'b0;
      run(1'b1, 7'h7c, 4, 32'h0);
      chk(nack, 1'b0);
      chk(rd_data, mread(7'h7c, 4));
      conclude();
   end
endmodule // two_wire_eeprom_slave_port_tb_top
